// ==== hw/xisa_pkg.sv ====
// Contract
// RL1 - Extended features stay off unless the enable fuse reads one at startup
// RL2 - When enabled, eight extra opcodes beyond the 75 standard ones decode
// RL3 - Pointer add E8 / sub E9: select, six-bit literal, one cycle, no flags
// RL4 - Select 11 adjusts stack pointer by literal then returns, two cycles
// RL5 - Call via working register is 0014, two cycles, no flags touched
// RL6 - Stack moves EB: bit7 picks form, second word F plus address or offset
// RL7 - Push EA stores literal at stack pointer, then decrements it, one cycle
// RL8 - Indexed literal offset mode applies to standard byte and bit operations
// RL9 - Access bit clear and operand at most 5F means stack pointer offset
package xisa_pkg;

  // ******************************************************
  // Sizes and counts
  // ******************************************************
  localparam int STD_OPS   = 75;          // Standard opcode count
  localparam int EXT_OPS   = 8;           // Extra opcodes when enabled
  localparam int PTR_W     = 12;          // Pointer and data address width
  localparam int PTR_COUNT = 3;
  localparam int SP_IDX    = 2;           // Pointer used as software stack

  // ******************************************************
  // Encodings
  // ******************************************************
  localparam logic [7:0]  OPC_PTR_ADD = 8'hE8;
  localparam logic [7:0]  OPC_PTR_SUB = 8'hE9;
  localparam logic [7:0]  OPC_PUSH    = 8'hEA;
  localparam logic [7:0]  OPC_MOVE    = 8'hEB;
  localparam logic [15:0] OPC_CALL_W  = 16'h0014;
  localparam logic [3:0]  OPC_WORD2   = 4'hF;
  localparam logic [1:0]  SEL_STACK   = 2'h3;
  localparam int          MOVE_KIND_BIT = 7;  // Set: stack-to-stack form
  localparam int          ACCESS_BIT    = 8;  // Access-bank select in word
  localparam logic [7:0]  INDEX_LIMIT = 8'h5F;
  localparam logic [11:0] PTR_RST     = 12'h000;
  localparam logic [11:0] PUSH_STEP   = 12'h001;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MOVE2 = 2'b01,
    ST_FLUSH = 2'b10
  } seq_t;

  typedef struct packed {
    logic        rd;
    logic [11:0] rd_addr;
    logic        wr;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;
  } mem_req_t;

  typedef struct packed {
    logic       ret;
    logic       call;
    logic [7:0] call_low;
  } flow_t;

endpackage

// ==== hw/index_mapper.sv ====
`timescale 1ns/1ps
module index_mapper #(
  parameter int ADDR_W = 12
) (
  input  wire logic              enable,
  input  wire logic [7:0]        file_op,
  input  wire logic              access_sel,
  input  wire logic [ADDR_W-1:0] base,
  output logic                   indexed,
  output logic [ADDR_W-1:0]      eff_addr
);
  import xisa_pkg::*;

  // ******************************************************
  // Operand mapping
  // ******************************************************
  if (ADDR_W < 8) begin : g_bad_width
    $error("index_mapper: ADDR_W must be at least 8");
  end

  // Low operands with access bit clear become stack pointer offsets
  assign indexed  = enable & ~access_sel & (file_op <= INDEX_LIMIT); // [RL9]
  assign eff_addr = indexed ? base + ADDR_W'(file_op)
                            : ADDR_W'(file_op);
endmodule

// ==== hw/ext_isa_decoder.sv ====
`timescale 1ns/1ps
module ext_isa_decoder #(
  parameter int ADDR_W = xisa_pkg::PTR_W
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  input  wire logic                ext_set_enable_fuse,
  input  wire logic                ins_valid,
  input  wire logic [15:0]         ins_word,
  input  wire logic                std_file_op,
  input  wire logic [7:0]          working_reg,
  input  wire logic [7:0]          mem_rdata,
  output xisa_pkg::mem_req_t       mem_req,
  output xisa_pkg::flow_t          flow,
  output logic                     busy,
  output logic                     ext_hit,
  output logic                     indexed,
  output logic [11:0]              eff_addr,
  output logic [11:0]              stack_pointer_reg
);
  import xisa_pkg::*;

  if (ADDR_W != PTR_W) begin : g_bad_width
    $error("ext_isa_decoder: ADDR_W must equal the pointer width");
  end

  // ******************************************************
  // Reset release
  // ******************************************************
  logic rst_meta;
  logic rst_n;

  // Two stages so release never lands mid-cycle on the state below
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ******************************************************
  // State
  // ******************************************************
  seq_t        seq,      next_seq;
  logic        ext_on,   next_ext_on;
  logic        cap_done, next_cap_done;
  logic        mv_kind,  next_mv_kind;
  logic [11:0] ptr      [PTR_COUNT];
  logic [11:0] next_ptr [PTR_COUNT];
  mem_req_t    next_mem_req;
  flow_t       next_flow;
  logic        next_busy;
  logic        next_ext_hit;
  logic        next_indexed;
  logic [11:0] next_eff_addr;

  logic        adj_en;
  logic [1:0]  adj_idx;
  logic        adj_sub;
  logic [11:0] adj_amt;
  logic        map_idx;
  logic [11:0] map_addr;

  // Decode terms, only live in an idle cycle with the extension on
  logic       dec_go;
  logic [7:0] opc_hi;
  logic       dec_addsub;
  logic       dec_push;
  logic       dec_move;
  logic       dec_call;

  assign opc_hi     = ins_word[15:8];
  assign dec_go     = ins_valid & ext_on & (seq == ST_IDLE); // [RL1]
  assign dec_addsub = dec_go & ((opc_hi == OPC_PTR_ADD) |
                                (opc_hi == OPC_PTR_SUB));
  assign dec_push   = dec_go & (opc_hi == OPC_PUSH);
  assign dec_move   = dec_go & (opc_hi == OPC_MOVE);
  assign dec_call   = dec_go & (ins_word == OPC_CALL_W);

  assign stack_pointer_reg = ptr[SP_IDX];

  // Standard byte and bit operands pass through the offset mapper
  index_mapper #(
    .ADDR_W (PTR_W)
  ) u_map (
    .enable     (ext_on & std_file_op & (seq == ST_IDLE)), // [RL8]
    .file_op    (ins_word[7:0]),
    .access_sel (ins_word[ACCESS_BIT]),
    .base       (ptr[SP_IDX]),
    .indexed    (map_idx),
    .eff_addr   (map_addr)
  );

  // ******************************************************
  // Pointer file
  // ******************************************************
  // One adder per pointer; only the selected one moves
  for (genvar g = 0; g < PTR_COUNT; g++) begin : g_ptr
    assign next_ptr[g] = (adj_en && adj_idx == 2'(g))
                         ? (adj_sub ? ptr[g] - adj_amt : ptr[g] + adj_amt)
                         : ptr[g];
  end

  // ******************************************************
  // Sequencer and decode
  // ******************************************************
  // Outputs other than eff_addr and stack_pointer_reg are pulses; a flush slot stands in for the core's dead cycle
  always_comb begin
    next_seq      = seq;
    next_ext_on   = ext_on;
    next_cap_done = cap_done;
    next_mv_kind  = mv_kind;
    next_mem_req  = '0;
    next_flow     = '0;
    next_busy     = 1'b0;
    next_ext_hit  = 1'b0;
    next_indexed  = 1'b0;
    next_eff_addr = eff_addr;
    adj_en        = 1'b0;
    adj_idx       = SEL_STACK;
    adj_sub       = 1'b0;
    adj_amt       = 12'h000;
    // Fuse is sampled once; later changes are ignored until reset
    if (!cap_done) begin
      next_ext_on   = ext_set_enable_fuse;                 // [RL1]
      next_cap_done = 1'b1;
    end
    next_ext_hit = dec_addsub | dec_push | dec_move | dec_call; // [RL2]
    case (seq)
      ST_IDLE: begin
        if (dec_addsub) begin
          adj_en  = 1'b1;                                  // [RL3]
          adj_sub = (opc_hi == OPC_PTR_SUB);
          adj_amt = {6'h00, ins_word[5:0]};
          if (ins_word[7:6] == SEL_STACK) begin
            adj_idx        = 2'(SP_IDX);                   // [RL4]
            next_flow.ret  = 1'b1;
            next_busy      = 1'b1;
            next_seq       = ST_FLUSH;
          end else begin
            adj_idx = ins_word[7:6];
          end
        end else if (dec_push) begin
          next_mem_req.wr      = 1'b1;                     // [RL7]
          next_mem_req.wr_addr = ptr[SP_IDX];
          next_mem_req.wr_data = ins_word[7:0];
          adj_en  = 1'b1;
          adj_idx = 2'(SP_IDX);
          adj_sub = 1'b1;
          adj_amt = PUSH_STEP;
        end else if (dec_move) begin
          next_mem_req.rd      = 1'b1;                     // [RL6]
          next_mem_req.rd_addr = ptr[SP_IDX] + {5'h00, ins_word[6:0]};
          next_mv_kind         = ins_word[MOVE_KIND_BIT];
          next_seq             = ST_MOVE2;
        end else if (dec_call) begin
          next_flow.call     = 1'b1;                       // [RL5]
          next_flow.call_low = working_reg;
          next_busy          = 1'b1;
          next_seq           = ST_FLUSH;
        end else if (ins_valid) begin
          next_indexed  = map_idx;                         // [RL9]
          next_eff_addr = map_addr;
        end
      end
      ST_MOVE2: begin
        // Second word carries the destination; a stray word is dropped
        if (ins_valid) begin
          next_seq = ST_IDLE;
          if (ins_word[15:12] == OPC_WORD2) begin
            next_mem_req.wr      = 1'b1;                   // [RL6]
            next_mem_req.wr_data = mem_rdata;
            next_mem_req.wr_addr = mv_kind
              ? ptr[SP_IDX] + {5'h00, ins_word[6:0]}
              : ins_word[11:0];
          end
        end
      end
      ST_FLUSH: next_seq = ST_IDLE;
      default:  next_seq = ST_IDLE;
    endcase
  end

  // Clock enable low holds every bit of state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq      <= ST_IDLE;
      ext_on   <= 1'b0;
      cap_done <= 1'b0;
      mv_kind  <= 1'b0;
      mem_req  <= '0;
      flow     <= '0;
      busy     <= 1'b0;
      ext_hit  <= 1'b0;
      indexed  <= 1'b0;
      eff_addr <= 12'h000;
      for (int i = 0; i < PTR_COUNT; i++) begin
        ptr[i] <= PTR_RST;
      end
    end else if (clk_en) begin
      seq      <= next_seq;
      ext_on   <= next_ext_on;
      cap_done <= next_cap_done;
      mv_kind  <= next_mv_kind;
      mem_req  <= next_mem_req;
      flow     <= next_flow;
      busy     <= next_busy;
      ext_hit  <= next_ext_hit;
      indexed  <= next_indexed;
      eff_addr <= next_eff_addr;
      for (int i = 0; i < PTR_COUNT; i++) begin
        ptr[i] <= next_ptr[i];
      end
    end
  end

  // ******************************************************
  // Checks
  // ******************************************************
  // Pointer picked by the select field, read before the adjust lands
  logic [11:0] sel_ptr;
  assign sel_ptr = (ins_word[7:6] == 2'h0) ? ptr[0]
                 : (ins_word[7:6] == 2'h1) ? ptr[1] : ptr[2];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  fuse_gate_a: assert property ( // [RL1]
    clk_en && !ext_on |=> !ext_hit && !flow.ret && !flow.call && !indexed)
    else $error("extended feature active with fuse off");

  ptr_adjust_a: assert property ( // [RL3]
    clk_en && dec_addsub && ins_word[7:6] != SEL_STACK |=>
      ptr[$past(ins_word[7:6])] == ($past(opc_hi) == OPC_PTR_SUB
        ? $past(sel_ptr) - {6'h00, $past(ins_word[5:0])}
        : $past(sel_ptr) + {6'h00, $past(ins_word[5:0])}))
    else $error("pointer literal adjust wrong");

  adjust_return_a: assert property ( // [RL4]
    clk_en && dec_addsub && ins_word[7:6] == SEL_STACK |=>
      flow.ret && busy && seq == ST_FLUSH ##1
      (!$past(clk_en) || (!busy && !flow.ret && seq == ST_IDLE)))
    else $error("adjust-and-return not two cycles");

  call_reg_a: assert property ( // [RL5]
    clk_en && dec_call |=> flow.call && busy &&
      flow.call_low == $past(working_reg))
    else $error("call via working register wrong");

  busy_slot_a: assert property ( // [RL4]
    busy |-> seq == ST_FLUSH)
    else $error("busy outside flush slot");

  move_first_a: assert property ( // [RL6]
    clk_en && dec_move |=> mem_req.rd && seq == ST_MOVE2 &&
      mem_req.rd_addr == $past(ptr[SP_IDX]) + {5'h00, $past(ins_word[6:0])})
    else $error("stack move source read wrong");

  move_second_a: assert property ( // [RL6]
    clk_en && seq == ST_MOVE2 && ins_valid &&
      ins_word[15:12] == OPC_WORD2 |=> mem_req.wr && seq == ST_IDLE &&
      mem_req.wr_data == $past(mem_rdata))
    else $error("stack move destination write wrong");

  push_lit_a: assert property ( // [RL7]
    clk_en && dec_push |=> mem_req.wr &&
      mem_req.wr_data == $past(ins_word[7:0]) &&
      mem_req.wr_addr == $past(ptr[SP_IDX]) &&
      ptr[SP_IDX] == $past(ptr[SP_IDX]) - PUSH_STEP)
    else $error("push literal wrong");

  index_mode_a: assert property ( // [RL9]
    clk_en && ext_on && seq == ST_IDLE && ins_valid && std_file_op &&
      !next_ext_hit && !ins_word[ACCESS_BIT] && ins_word[7:0] <= INDEX_LIMIT |=>
      indexed && eff_addr == $past(ptr[SP_IDX]) + {4'h0, $past(ins_word[7:0])})
    else $error("indexed offset mapping wrong");

  index_limit_a: assert property ( // [RL9]
    clk_en && ins_valid && ins_word[7:0] > INDEX_LIMIT |=> !indexed)
    else $error("operand above limit mapped as offset");

  cover_push_c:   cover property (clk_en && dec_push);
  cover_move_c:   cover property (clk_en && dec_move ##1 seq == ST_MOVE2);
  cover_return_c: cover property (flow.ret);
  cover_index_c:  cover property (indexed);
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("unexpected at %0t: %s", $time, msg); \
    end \
  end
module tb_top;
  import xisa_pkg::*;

  // ******************************************************
  // Stimulus and observed signals
  // ******************************************************
  logic        ref_clk;
  logic        rst_b;
  logic        clk_en;
  logic        ext_set_enable_fuse;
  logic        ins_valid;
  logic [15:0] ins_word;
  logic        std_file_op;
  logic [7:0]  working_reg;
  logic [7:0]  mem_rdata;
  mem_req_t    mem_req;
  flow_t       flow;
  logic        busy;
  logic        ext_hit;
  logic        indexed;
  logic [11:0] eff_addr;
  logic [11:0] stack_pointer_reg;
  int          num_errors;
  int          check_count;
  logic [11:0] exp_sp;

  ext_isa_decoder dut (
    .ref_clk             (ref_clk),
    .rst_b               (rst_b),
    .clk_en              (clk_en),
    .ext_set_enable_fuse (ext_set_enable_fuse),
    .ins_valid           (ins_valid),
    .ins_word            (ins_word),
    .std_file_op         (std_file_op),
    .working_reg         (working_reg),
    .mem_rdata           (mem_rdata),
    .mem_req             (mem_req),
    .flow                (flow),
    .busy                (busy),
    .ext_hit             (ext_hit),
    .indexed             (indexed),
    .eff_addr            (eff_addr),
    .stack_pointer_reg   (stack_pointer_reg)
  );

  // Free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ******************************************************
  // Drivers: every task starts and ends on a falling edge
  // ******************************************************
  // Word stays presented on return, so callers chain or go idle
  task automatic put(input logic [15:0] w, input logic s);
    ins_valid   = 1'b1;
    ins_word    = w;
    std_file_op = s;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic idle;
    ins_valid   = 1'b0;
    std_file_op = 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Fuse is only read once after release, so it is set inside reset
  task automatic do_reset(input logic fuse);
    @(negedge ref_clk);
    rst_b               = 1'b0;
    ext_set_enable_fuse = fuse;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    exp_sp = PTR_RST;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic test_fuse_off;
    put(16'hEA55, 1'b0);
    `CHK(ext_hit, 1'b0, "decoded with fuse off")
    `CHK(mem_req.wr, 1'b0, "push ran with fuse off")
    put(16'h1A10, 1'b1);
    `CHK(indexed, 1'b0, "indexed with fuse off")
    `CHK(eff_addr, 12'h010, "direct address wrong")
    idle();
    $display("test fuse_off done");
  endtask

  // Add, skip other pointer, subtract through zero, add back
  task automatic test_pointer;
    put(16'hE8A3, 1'b0);
    exp_sp = exp_sp + 12'h023;
    `CHK(ext_hit, 1'b1, "add not decoded")
    `CHK(stack_pointer_reg, exp_sp, "add result")
    put(16'hE805, 1'b0);
    `CHK(ext_hit, 1'b1, "add sel0 not decoded")
    `CHK(stack_pointer_reg, exp_sp, "sel0 touched stack")
    put(16'hE9BF, 1'b0);
    exp_sp = exp_sp - 12'h03F;
    `CHK(stack_pointer_reg, exp_sp, "sub wrap result")
    put(16'hE8BF, 1'b0);
    exp_sp = exp_sp + 12'h03F;
    `CHK(stack_pointer_reg, exp_sp, "add wrap result")
    idle();
    $display("test pointer done");
  endtask

  task automatic test_push;
    // Frozen core must not take the word
    clk_en = 1'b0;
    put(16'hEA11, 1'b0);
    `CHK(stack_pointer_reg, exp_sp, "push while frozen")
    clk_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      put({8'hEA, i[0] ? 8'hA5 : 8'h5A}, 1'b0);
      `CHK(mem_req.wr, 1'b1, "push no write")
      `CHK(mem_req.wr_addr, exp_sp, "push address")
      `CHK(mem_req.wr_data, i[0] ? 8'hA5 : 8'h5A, "push data")
      exp_sp = exp_sp - PUSH_STEP;
      `CHK(stack_pointer_reg, exp_sp, "push decrement")
    end
    idle();
    $display("test push done");
  endtask

  // Adjust-and-return both ways, with a word offered in the dead slot
  task automatic test_return;
    for (int i = 0; i < 2; i++) begin
      put(i[0] ? 16'hE9C1 : 16'hE8C3, 1'b0);
      exp_sp = i[0] ? exp_sp - 12'h001 : exp_sp + 12'h003;
      `CHK(flow.ret, 1'b1, "no return")
      `CHK(busy, 1'b1, "no second cycle")
      `CHK(stack_pointer_reg, exp_sp, "adjust value")
      put(16'hEA11, 1'b0);
      `CHK(busy, 1'b0, "busy too long")
      `CHK(flow.ret, 1'b0, "return too long")
      `CHK(mem_req.wr, 1'b0, "word taken in dead slot")
    end
    idle();
    $display("test return done");
  endtask

  task automatic test_call;
    working_reg = 8'h7B;
    put(OPC_CALL_W, 1'b0);
    working_reg = 8'h84;
    `CHK(flow.call, 1'b1, "no call")
    `CHK(flow.call_low, 8'h7B, "call target")
    `CHK(busy, 1'b1, "call not two cycles")
    `CHK(stack_pointer_reg, exp_sp, "call touched stack")
    idle();
    `CHK(busy, 1'b0, "call busy too long")
    `CHK(flow.call, 1'b0, "call pulse too long")
    $display("test call done");
  endtask

  // Both move forms, then a broken second word that must be dropped
  task automatic test_move;
    put(16'hEB05, 1'b0);
    `CHK(mem_req.rd, 1'b1, "move no read")
    `CHK(mem_req.rd_addr, exp_sp + 12'h005, "move source")
    mem_rdata = 8'hC6;
    put(16'hF123, 1'b0);
    mem_rdata = 8'h39;
    `CHK(mem_req.wr, 1'b1, "move no write")
    `CHK(mem_req.wr_addr, 12'h123, "move file dest")
    `CHK(mem_req.wr_data, 8'hC6, "move data")
    put(16'hEB85, 1'b0);
    `CHK(mem_req.rd_addr, exp_sp + 12'h005, "stack move source")
    mem_rdata = 8'h3D;
    put(16'hF007, 1'b0);
    mem_rdata = 8'hC2;
    `CHK(mem_req.wr_addr, exp_sp + 12'h007, "stack move dest")
    `CHK(mem_req.wr_data, 8'h3D, "stack move data")
    put(16'hEB05, 1'b0);
    put(16'h0123, 1'b0);
    `CHK(mem_req.wr, 1'b0, "bad second word wrote")
    idle();
    $display("test move done");
  endtask

  // Offset boundary, one above it, and access bit set
  task automatic test_index;
    put(16'h1A5F, 1'b1);
    `CHK(indexed, 1'b1, "limit not indexed")
    `CHK(eff_addr, exp_sp + 12'h05F, "indexed address")
    put(16'h1A60, 1'b1);
    `CHK(indexed, 1'b0, "above limit indexed")
    `CHK(eff_addr, 12'h060, "above limit address")
    put(16'h1B10, 1'b1);
    `CHK(indexed, 1'b0, "access bit ignored")
    `CHK(eff_addr, 12'h010, "banked address")
    idle();
    $display("test index done");
  endtask

  // ******************************************************
  // Main sequence and hang guard
  // ******************************************************
  initial begin
    rst_b               = 1'b0;
    clk_en              = 1'b1;
    ext_set_enable_fuse = 1'b0;
    ins_valid           = 1'b0;
    ins_word            = 16'h0000;
    std_file_op         = 1'b0;
    working_reg         = 8'h00;
    mem_rdata           = 8'h00;
    num_errors          = 0;
    check_count         = 0;
    do_reset(1'b0);
    test_fuse_off();
    do_reset(1'b1);
    test_pointer();
    test_push();
    test_return();
    test_call();
    test_move();
    test_index();
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    $display("unexpected at %0t: run too long", $time);
    stop_test();
  end
endmodule
